// ### verilog/cgv_channel_regs.sv
// Purpose: Channel two gain, volume and calibration registers with channel three volume.
// Assumes: Register port comes decoded from the control serial interface, same clock.
// Notes: Channel two settings reach the sample path only on a sample strobe, all fields together; channel three volume is output as soon as written.
`include "cgv_map.svh"

// Contract
// - Gain code N gives N half-dB; codes 84 and above give 42 dB.
// - Polarity bit set makes gain negative, floored at -11 dB.
// - Gain field resets to code zero, positive: 0 dB.
// - Volume code zero mutes the channel output.
// - Volume codes step half-dB: 1 is -100, 201 is 0, 255 is +27 dB.
// - Channel two volume at 0x43 resets to 0xC9.
// - Trim code steps 0.1 dB: 0 is -0.8, 8 is 0, 15 is +0.7 dB.
// - Trim register at 0x44 resets to 0x80.
// - Phase field delays channel by N modulator clock cycles.
// - Phase register at 0x45 resets to 0x00.
// - Channel three volume at 0x48 resets to 0xC9.
module cgv_channel_regs
  import cgv_pkg::*;
#(
  parameter int SW = 24,
  parameter int MOD_DIV = `CGV_MOD_DIV
)(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic smp_valid,
  input wire logic signed [SW-1:0] smp_data,
  output logic smp_out_valid,
  output logic signed [SW-1:0] smp_out_data,
  output cgv_applied_t applied,
  output logic [7:0] ch3_vol_code,
  input wire logic mod_bit_in,
  output logic mod_bit_out
);
  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    cgv_regs_t regs;
    cgv_applied_t app;
    logic [7:0] rdata;
    logic out_valid;
    logic [SW-1:0] out_data;
    logic [7:0] div_cnt;
    logic mod_en;
    logic any_wr;
  } cgv_state_t;

  cgv_state_t st_q;
  cgv_state_t st_d;
  logic signed [7:0] gain_lin;

  // Refuse parameters the 8-bit divider and the sample path cannot serve
  if (MOD_DIV < 1 || MOD_DIV > 256)
  begin : g_bad_div
    $error("Modulator divider out of range");
  end
  if (SW < 2)
  begin : g_bad_sw
    $error("Sample width too small");
  end

  always_comb
  begin
    st_d = st_q;
    st_d.mod_en = 1'b0;
    st_d.out_valid = 1'b0;
    gain_lin = '0;
    // Modulator cycle enable
    if (st_q.div_cnt == 8'(MOD_DIV - 1))
    begin
      st_d.div_cnt = 8'h00;
      st_d.mod_en = 1'b1;
    end
    else
      st_d.div_cnt = st_q.div_cnt + 8'h01;
    // Register writes
    if (reg_wr)
    begin
      st_d.any_wr = 1'b1;
      case (reg_addr)
        `CGV_ADDR_GAIN:
        begin
          st_d.regs.gain_code = reg_wdata[`CGV_GAIN_MSB:`CGV_GAIN_LSB];
          st_d.regs.gain_polarity = reg_wdata[`CGV_SIGN_BIT];
        end
        `CGV_ADDR_VOL: st_d.regs.vol_code = reg_wdata;
        `CGV_ADDR_TRIM: st_d.regs.gain_trim = reg_wdata[`CGV_TRIM_MSB:`CGV_TRIM_LSB];
        `CGV_ADDR_PHASE: st_d.regs.phase_delay = reg_wdata;
        `CGV_ADDR_CH3_VOL: st_d.regs.ch3_vol_code = reg_wdata;
        default: st_d.any_wr = st_q.any_wr;
      endcase
    end
    // Register reads; unmapped and reserved bits read zero
    if (reg_rd)
    begin
      case (reg_addr)
        `CGV_ADDR_GAIN: st_d.rdata = {st_q.regs.gain_code, st_q.regs.gain_polarity};
        `CGV_ADDR_VOL: st_d.rdata = st_q.regs.vol_code;
        `CGV_ADDR_TRIM: st_d.rdata = {st_q.regs.gain_trim, 4'h0};
        `CGV_ADDR_PHASE: st_d.rdata = st_q.regs.phase_delay;
        `CGV_ADDR_CH3_VOL: st_d.rdata = st_q.regs.ch3_vol_code;
        default: st_d.rdata = 8'h00;
      endcase
    end
    // Snapshot of all channel two settings at each sample
    if (smp_valid)
    begin
      if (st_q.regs.gain_code > `CGV_GAIN_MAX)
        gain_lin = $signed({1'b0, `CGV_GAIN_MAX});
      else
        gain_lin = $signed({1'b0, st_q.regs.gain_code});
      if (st_q.regs.gain_polarity)
        gain_lin = -gain_lin;
      if (gain_lin < $signed(`CGV_NEG_FLOOR))
        gain_lin = $signed(`CGV_NEG_FLOOR);
      st_d.app.gain_half_db = gain_lin;
      st_d.app.mute = (st_q.regs.vol_code == 8'h00);
      st_d.app.vol_half_db = $signed({1'b0, st_q.regs.vol_code}) - $signed(`CGV_VOL_UNITY);
      st_d.app.trim_tenth_db = $signed({1'b0, st_q.regs.gain_trim})
        - $signed(`CGV_TRIM_UNITY);
      st_d.app.phase_delay = st_q.regs.phase_delay;
      st_d.out_valid = 1'b1;
      st_d.out_data = (st_q.regs.vol_code == 8'h00) ? '0 : smp_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_q <= '0;
      st_q.regs.gain_code <= 7'(`CGV_RST_GAIN >> 1);
      st_q.regs.gain_polarity <= 1'b0;
      st_q.regs.vol_code <= `CGV_RST_VOL;
      st_q.regs.gain_trim <= 4'(`CGV_RST_TRIM >> 4);
      st_q.regs.phase_delay <= `CGV_RST_PHASE;
      st_q.regs.ch3_vol_code <= `CGV_RST_CH3_VOL;
      st_q.app.trim_tenth_db <= 5'h00;
    end
    else
      st_q <= st_d;
  end

  cgv_phase_delay #(.DEPTH(256)) u_phase (
    .clk(clk),
    .rst_n(rst_n),
    .mod_en(st_q.mod_en),
    .bit_in(mod_bit_in),
    .delay(st_q.app.phase_delay),
    .bit_out(mod_bit_out)
  );

  assign reg_rdata = st_q.rdata;
  assign smp_out_valid = st_q.out_valid;
  assign smp_out_data = st_q.out_data;
  assign applied = st_q.app;
  assign ch3_vol_code = st_q.regs.ch3_vol_code;

  // ****************************************
  // Checks
  // ****************************************
  vol_mute_a: assert property (@(posedge clk) disable iff (!rst_n)
    smp_valid && st_q.regs.vol_code == 8'h00 |=> smp_out_valid && smp_out_data == '0
    && applied.mute)
    else $error("Volume code zero did not mute");
  vol_pass_a: assert property (@(posedge clk) disable iff (!rst_n)
    smp_valid && st_q.regs.vol_code != 8'h00 |=> smp_out_data == $past(smp_data) && !applied.mute)
    else $error("Nonzero volume sample was altered");
  vol_map_a: assert property (@(posedge clk) disable iff (!rst_n)
    smp_valid |=> applied.vol_half_db == $signed({1'b0, $past(st_q.regs.vol_code)}) - 9'sd201)
    else $error("Volume code mapped wrongly");
  gain_map_a: assert property (@(posedge clk) disable iff (!rst_n)
    smp_valid && !st_q.regs.gain_polarity && st_q.regs.gain_code <= 7'd84
    |=> applied.gain_half_db == $signed({1'b0, $past(st_q.regs.gain_code)}))
    else $error("Positive gain code mapped wrongly");
  gain_floor_a: assert property (@(posedge clk) disable iff (!rst_n)
    smp_valid && st_q.regs.gain_polarity |=> applied.gain_half_db <= 8'sd0
    && applied.gain_half_db >= -8'sd22)
    else $error("Negative gain outside its range");
  trim_map_a: assert property (@(posedge clk) disable iff (!rst_n)
    smp_valid |=> applied.trim_tenth_db == $signed({1'b0, $past(st_q.regs.gain_trim)}) - 5'sd8)
    else $error("Trim code mapped wrongly");
  trim_rsvd_a: assert property (@(posedge clk) disable iff (!rst_n)
    reg_rd && reg_addr == 8'h44 |=> reg_rdata[3:0] == 4'h0)
    else $error("Reserved trim bits read nonzero");
  reset_vals_a: assert property (@(posedge clk) disable iff (!rst_n)
    !st_q.any_wr |-> st_q.regs == {7'h00, 1'b0, 8'hC9, 4'h8, 8'h00, 8'hC9})
    else $error("Register left reset value without a write");
  apply_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    !smp_valid |=> $stable(applied))
    else $error("Settings changed between samples");
  mod_rate_a: assert property (@(posedge clk) disable iff (!rst_n)
    st_q.mod_en |=> !st_q.mod_en [*1] or MOD_DIV == 1)
    else $error("Modulator enable not a single pulse");

  mute_seen_c: cover property (@(posedge clk) disable iff (!rst_n) smp_out_valid && applied.mute);
  neg_gain_c: cover property (@(posedge clk) disable iff (!rst_n)
    smp_out_valid && applied.gain_half_db == -8'sd22);
  vol_write_c: cover property (@(posedge clk) disable iff (!rst_n)
    reg_wr && reg_addr == 8'h43 ##[1:20] smp_out_valid);
  max_phase_c: cover property (@(posedge clk) disable iff (!rst_n) applied.phase_delay == 8'hFF);
endmodule : cgv_channel_regs

// ### verilog/cgv_map.svh
// Purpose: Offsets, field positions, reset values and limits of the channel register bank.
// Assumes: 8-bit register address and data on the control register port.
// Notes: Definitions only.
`ifndef CGV_MAP_SVH
`define CGV_MAP_SVH
// ****************************************
// Register offsets
// ****************************************
`define CGV_ADDR_GAIN 8'h42
`define CGV_ADDR_VOL 8'h43
`define CGV_ADDR_TRIM 8'h44
`define CGV_ADDR_PHASE 8'h45
`define CGV_ADDR_CH3_VOL 8'h48
// ****************************************
// Reset values
// ****************************************
`define CGV_RST_GAIN 8'h00
`define CGV_RST_VOL 8'hC9
`define CGV_RST_TRIM 8'h80
`define CGV_RST_PHASE 8'h00
`define CGV_RST_CH3_VOL 8'hC9
// ****************************************
// Field positions
// ****************************************
`define CGV_GAIN_MSB 7
`define CGV_GAIN_LSB 1
`define CGV_SIGN_BIT 0
`define CGV_TRIM_MSB 7
`define CGV_TRIM_LSB 4
// ****************************************
// Code mapping limits, half-dB and tenth-dB units
// ****************************************
`define CGV_GAIN_MAX 7'h54
`define CGV_NEG_FLOOR 8'hEA
`define CGV_VOL_UNITY 9'h0C9
`define CGV_TRIM_UNITY 5'h08
`define CGV_MOD_DIV 8
`endif

// ### verilog/cgv_pkg.sv
// Purpose: Types shared by the channel register bank and its phase delay line.
// Assumes: Nothing beyond the map header.
// Notes: Settings travel as packed structs.
package cgv_pkg;
  // ****************************************
  // Stored register contents
  // ****************************************
  typedef struct packed {
    logic [6:0] gain_code;
    logic gain_polarity;
    logic [7:0] vol_code;
    logic [3:0] gain_trim;
    logic [7:0] phase_delay;
    logic [7:0] ch3_vol_code;
  } cgv_regs_t;

  // ****************************************
  // Settings applied to the sample path
  // ****************************************
  typedef struct packed {
    logic signed [7:0] gain_half_db;
    logic mute;
    logic signed [8:0] vol_half_db;
    logic signed [4:0] trim_tenth_db;
    logic [7:0] phase_delay;
  } cgv_applied_t;
endpackage : cgv_pkg

// ### verilog/cgv_phase_delay.sv
// Purpose: Delays the modulator bitstream by a programmed count of modulator cycles.
// Assumes: mod_en is a one-cycle pulse per modulator cycle.
// Notes: Output is registered; zero delay passes the bit with one clk of latency.
module cgv_phase_delay
  import cgv_pkg::*;
#(
  parameter int DEPTH = 256
)(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic mod_en,
  input wire logic bit_in,
  input wire logic [7:0] delay,
  output logic bit_out
);
  typedef struct packed {
    logic [DEPTH-1:0] hist;
    logic out;
  } cgv_dly_state_t;

  cgv_dly_state_t st_q;
  cgv_dly_state_t st_d;

  // Refuse a line too short for the largest programmable delay
  if (DEPTH < 256)
  begin : g_bad_depth
    $error("Delay line must hold 255 modulator cycles");
  end

  always_comb
  begin
    st_d = st_q;
    if (mod_en)
    begin
      st_d.hist = {st_q.hist[DEPTH-2:0], bit_in};
      if (delay == 8'h00)
        st_d.out = bit_in;
      else
        st_d.out = st_q.hist[delay - 8'h01];
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  assign bit_out = st_q.out;

  // ****************************************
  // Checks
  // ****************************************
  dly_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
    mod_en && delay == 8'h00 |=> bit_out == $past(bit_in))
    else $error("Zero phase delay did not pass the bit");
  dly_one_a: assert property (@(posedge clk) disable iff (!rst_n)
    mod_en && delay == 8'h01 |=> bit_out == $past(st_q.hist[0]))
    else $error("Unit phase delay did not repeat the previous bit");
endmodule : cgv_phase_delay

// ### verif/cgv_host_model.sv
// Purpose: Host model that drives the register port of the channel bank.
// Assumes: Requests change on the falling clock edge and are taken on the rising one.
// Notes: raw lets a scenario send reserved values on purpose.
module cgv_host_model (
  input wire logic clk,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  // Channel input impedance flag, set high here; when low, non-raw gain writes clear the polarity bit
  logic hi_imp;
  initial
  begin
    hi_imp = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic raw);
    logic [7:0] v;
    v = d;
    if (a == 8'h44 && !raw)
      v = d & 8'hF0;
    if (a == 8'h42 && !raw && d[7:1] > 7'h54)
      v = {7'h54, d[0]};
    if (a == 8'h42 && !raw && !hi_imp)
      v[0] = 1'b0;
    @(negedge clk);
    reg_addr = a;
    reg_wdata = v;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
    reg_wdata = ~d;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    reg_addr = ~a;
    @(negedge clk);
    d = reg_rdata;
  endtask : rd
endmodule : cgv_host_model

// ### verif/channel_gain_volume_calib_regs_bench.sv
// Purpose: Self-checking bench for the channel register bank.
// Assumes: Inputs change on the falling edge; modulator divider shortened to 4.
// Notes: Expected values are worked out from the code mappings.
module channel_gain_volume_calib_regs_bench import cgv_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int MD = 4;
  logic clk;
  logic rst_n;
  logic reg_wr, reg_rd, smp_valid, smp_out_valid, mod_bit_in, mod_bit_out;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, ch3_vol_code, rv;
  logic signed [23:0] smp_data, smp_out_data;
  cgv_applied_t applied;
  int bad_count = 0;
  int num_checks = 0;
  int cyc = 0;
  int lat;

  cgv_channel_regs #(.SW(24), .MOD_DIV(MD)) dut (.clk(clk), .rst_n(rst_n), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .smp_valid(smp_valid), .smp_data(smp_data), .smp_out_valid(smp_out_valid),
    .smp_out_data(smp_out_data), .applied(applied), .ch3_vol_code(ch3_vol_code),
    .mod_bit_in(mod_bit_in), .mod_bit_out(mod_bit_out));
  cgv_host_model host (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      bad_count++;
      final_report();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic final_report;
    $display("checks=%0d mismatches=%0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : final_report

  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    host.rd(a, rv);
    check(rv, e);
  endtask : rchk

  task automatic put(input logic [7:0] a, input logic [7:0] w);
    host.wr(a, w, 1'b1);
    @(negedge clk);
    smp_valid = 1'b1;
    smp_data = 24'h0ABCDE;
    @(negedge clk);
    smp_valid = 1'b0;
    check(smp_out_valid, 1'b1);
    @(negedge clk);
    check(smp_out_valid, 1'b0);
  endtask : put

  task automatic gcase(input logic [7:0] w, input logic [7:0] e);
    put(8'h42, w);
    check($unsigned(applied.gain_half_db), e);
  endtask : gcase

  task automatic vcase(input logic [7:0] w, input logic [8:0] e, input logic m);
    put(8'h43, w);
    check($unsigned(applied.vol_half_db), e);
    check(applied.mute, m);
    check(smp_out_data, m ? 24'h0 : 24'h0ABCDE);
  endtask : vcase

  task automatic ph(input int n);
    put(8'h45, n[7:0]);
    mod_bit_in = 1'b0;
    repeat ((n + 2) * MD + 4) @(negedge clk);
    mod_bit_in = 1'b1;
    lat = 0;
    while (mod_bit_out !== 1'b1 && lat < 400)
    begin
      @(negedge clk);
      lat++;
    end
    mod_bit_in = 1'b0;
  endtask : ph

  // ****************************************
  // Tests
  // ****************************************
  initial
  begin
    rst_n = 1'b0;
    smp_valid = 1'b0;
    smp_data = 24'h0;
    mod_bit_in = 1'b0;
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    check(ch3_vol_code, 8'hC9);
    rchk(8'h42, 8'h00);
    rchk(8'h43, 8'hC9);
    rchk(8'h44, 8'h80);
    rchk(8'h45, 8'h00);
    rchk(8'h48, 8'hC9);
    rchk(8'h46, 8'h00);
    $display("reset values done");
    host.wr(8'h44, 8'hFF, 1'b1);
    rchk(8'h44, 8'hF0);
    host.wr(8'h43, 8'h55, 1'b0);
    rchk(8'h43, 8'h55);
    host.wr(8'h46, 8'h77, 1'b0);
    rchk(8'h46, 8'h00);
    host.wr(8'h48, 8'h12, 1'b0);
    rchk(8'h48, 8'h12);
    check(ch3_vol_code, 8'h12);
    check($unsigned(applied.vol_half_db), 9'h000);
    put(8'h45, 8'h00);
    check($unsigned(applied.vol_half_db), 9'h18C);
    $display("access done");
    gcase(8'h02, 8'h01);
    gcase(8'hA8, 8'h54);
    gcase(8'hA9, 8'hEA);
    gcase(8'h03, 8'hFF);
    gcase(8'h2B, 8'hEB);
    gcase(8'h2F, 8'hEA);
    gcase(8'hFE, 8'h54);
    gcase(8'h00, 8'h00);
    $display("gain done");
    vcase(8'h00, 9'h137, 1'b1);
    vcase(8'h01, 9'h138, 1'b0);
    vcase(8'hC9, 9'h000, 1'b0);
    vcase(8'hFF, 9'h036, 1'b0);
    put(8'h44, 8'h00);
    check($unsigned(applied.trim_tenth_db), 5'h18);
    put(8'h44, 8'hF0);
    check($unsigned(applied.trim_tenth_db), 5'h07);
    put(8'h44, 8'h80);
    check($unsigned(applied.trim_tenth_db), 5'h00);
    $display("volume and trim done");
    ph(0);
    check(lat > 0 && lat <= MD + 2, 1'b1);
    ph(5);
    check(lat > 5 * MD && lat <= 6 * MD + 2, 1'b1);
    check(applied.phase_delay, 8'h05);
    $display("phase delay done");
    final_report();
  end
endmodule : channel_gain_volume_calib_regs_bench
